// file: hdl/atc_defines.vh
// constants for the acquisition trigger controller: source, type and pulse class codes, timing counts
// assumes the includer runs on a 100 MHz sample clock; counts are derived from the clock period
// Behaviour
// - flag edge when source crosses level
// - slope picks rising or falling crossings
// - keep writing, always retain pretrigger samples
// - after trigger fill posttrigger, then stop
// - trigger address marks record time zero
// - ignore triggers until acquisition completes
// - holdoff disables trigger after each acquisition
// - holdoff 0% min to 100% max
// - normal mode acquires only on real or forced trigger
// - force request gives exactly one acquisition
// - auto mode timer forces missing trigger
// - auto timeout follows time base setting
// - selected channel triggers even when hidden
// - line source generated internally, no input
// - logic trigger: state and pattern variants
// - pulse trigger: width, runt, glitch classes
`ifndef ATC_DEFINES_VH
`define ATC_DEFINES_VH

// trigger source select codes
`define ATC_SRC_LINE 3'h4
`define ATC_SRC_AUX 3'h5

// trigger type codes
`define ATC_TYPE_EDGE 2'h0
`define ATC_TYPE_PULSE 2'h1
`define ATC_TYPE_LOGIC 2'h2

// pulse classes
`define ATC_PULSE_WIDTH 2'h0
`define ATC_PULSE_RUNT 2'h1
`define ATC_PULSE_GLITCH 2'h2

// holdoff percentage full scale
`define ATC_PCT_MAX 32'h0000_0064
`define ATC_PCT_RESET 7'h00

// timing figures in ns and the derived cycle counts
`define ATC_CLK_NS 10
`define ATC_HO_MIN_NS 1000
`define ATC_HO_MAX_NS 20000
`define ATC_AUTO_NS 40000
`define ATC_HO_MIN_CYC ((`ATC_HO_MIN_NS + `ATC_CLK_NS - 1) / `ATC_CLK_NS)
`define ATC_HO_MAX_CYC (`ATC_HO_MAX_NS / `ATC_CLK_NS)
`define ATC_AUTO_CYC (`ATC_AUTO_NS / `ATC_CLK_NS)
// half period of the internal line reference, 60 Hz at 100 MHz
`define ATC_LINE_HALF_CYC 833333

`endif

// file: hdl/atc_record_mem.v
// record memory: one write port, one read port with registered read data
// assumes a single clock shared by writer and reader
`timescale 1ns/100ps
module atc_record_mem #(
   parameter DW = 32,
   parameter AW = 10
) (
   input wire clk,
   input wire we,
   input wire [AW-1:0] waddr,
   input wire [DW-1:0] wdata,
   input wire [AW-1:0] raddr,
   output reg [DW-1:0] rdata
);
   reg [DW-1:0] mem [0:(1<<AW)-1];

   // read data registered so it meets timing into the display path
   always @(posedge clk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
      rdata <= mem[raddr];
   end
endmodule // atc_record_mem

// file: hdl/atc_trigger.v
// main trigger controller: edge, pulse and logic detection, record fill, holdoff and auto mode
// assumes channel samples arrive on REF_CLK with SAMPLE_VALID; the aux pin is asynchronous
`timescale 1ns/100ps
`include "atc_defines.vh"
module atc_trigger #(
   parameter SW = 8,
   parameter AW = 10,
   parameter LINE_HALF = `ATC_LINE_HALF_CYC,
   parameter HO_MIN = `ATC_HO_MIN_CYC,
   parameter HO_MAX = `ATC_HO_MAX_CYC,
   parameter AUTO_CYC = `ATC_AUTO_CYC
) (
   input wire REF_CLK,
   input wire RST,
   input wire RUN,
   input wire SAMPLE_VALID,
   input wire [4*SW-1:0] CH_DATA,
   input wire AUX_TRIG_PIN,
   input wire [2:0] TRIG_SOURCE,
   input wire [1:0] TRIG_TYPE,
   input wire [SW-1:0] TRIG_LEVEL,
   input wire [SW-1:0] TRIG_LEVEL_LOW,
   input wire SLOPE_FALLING,
   input wire AUTO_MODE,
   input wire FORCE_TRIG,
   input wire [6:0] HOLDOFF_PCT,
   input wire [3:0] HORIZ_SCALE,
   input wire [AW-1:0] PRE_LEN,
   input wire [AW-1:0] REC_LEN,
   input wire [1:0] PULSE_CLASS,
   input wire [15:0] PULSE_WIDTH,
   input wire [3:0] LOGIC_MASK,
   input wire [3:0] LOGIC_PATTERN,
   input wire LOGIC_OR,
   input wire LOGIC_STATE,
   input wire [AW-1:0] RD_ADDR,
   output wire [4*SW-1:0] RD_DATA,
   output reg [AW-1:0] TRIG_ADDR,
   output reg ACQ_DONE,
   output reg AUTO_FIRED,
   output wire ARMED,
   output wire [2:0] STATE
);
   localparam S_IDLE = 3'd0;
   localparam S_PRE = 3'd1;
   localparam S_ARM = 3'd2;
   localparam S_POST = 3'd3;
   localparam S_HOLD = 3'd4;

   reg [2:0] state;
   reg aux_s1, aux_s2;
   reg line_lvl;
   reg [31:0] line_cnt;
   reg src_prev, low_prev, match_prev, pulse_reached;
   reg [15:0] pulse_len;
   reg [AW-1:0] waddr, fill_cnt;
   reg [31:0] hold_cnt, auto_cnt;
   reg force_pend;

   // threshold compare shared by every detector
   function above;
      input [SW-1:0] s;
      input [SW-1:0] lvl;
      begin
         above = (s >= lvl);
      end
   endfunction

   // linear holdoff between the scale-dependent limits
   function [31:0] holdoff_cycles;
      input [6:0] pct;
      input [3:0] scale;
      reg [31:0] lo, hi;
      begin
         lo = HO_MIN << scale;
         hi = HO_MAX << scale;
         holdoff_cycles = lo + ((hi - lo) * {25'd0, pct}) / `ATC_PCT_MAX;
      end
   endfunction

   // aux pin comes from outside, two flops before use
   always @(posedge REF_CLK) begin
      if (RST) begin
         aux_s1 <= 1'b0;
         aux_s2 <= 1'b0;
      end else begin
         aux_s1 <= AUX_TRIG_PIN;
         aux_s2 <= aux_s1;
      end
   end

   // internal line reference, needs no input connection
   always @(posedge REF_CLK) begin
      if (RST) begin
         line_cnt <= 32'h0000_0000;
         line_lvl <= 1'b0;
      end else if (line_cnt >= LINE_HALF - 1) begin
         line_cnt <= 32'h0000_0000;
         line_lvl <= ~line_lvl;
      end else begin
         line_cnt <= line_cnt + 32'h0000_0001;
      end
   end

   // per-channel level bits; channels drive the detector whether displayed or not
   wire [3:0] ch_above;
   wire [3:0] ch_above_low;
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi = gi + 1) begin : g_cmp
         assign ch_above[gi] = above(CH_DATA[gi*SW +: SW], TRIG_LEVEL);
         assign ch_above_low[gi] = above(CH_DATA[gi*SW +: SW], TRIG_LEVEL_LOW);
      end
   endgenerate

   reg src_lvl, src_low;
   always @* begin
      src_lvl = 1'b0;
      src_low = 1'b0;
      if (TRIG_SOURCE == `ATC_SRC_LINE) begin
         src_lvl = line_lvl;
         src_low = line_lvl;
      end else if (TRIG_SOURCE == `ATC_SRC_AUX) begin
         src_lvl = aux_s2;
         src_low = aux_s2;
      end else if (TRIG_SOURCE[2] == 1'b0) begin
         src_lvl = ch_above[TRIG_SOURCE[1:0]];
         src_low = ch_above_low[TRIG_SOURCE[1:0]];
      end
   end

   // active sense of the source: falling slope inverts so one edge test serves both
   wire act = src_lvl ^ SLOPE_FALLING;
   wire act_low = src_low ^ SLOPE_FALLING;
   wire edge_hit = act & ~src_prev ^ 1'b0;
   wire pulse_end = ~act & src_prev;

   // logic pattern: and of masked matches, or any masked match
   wire [3:0] eq = ~(ch_above ^ LOGIC_PATTERN);
   wire match = LOGIC_OR ? |(eq & LOGIC_MASK) : &(eq | ~LOGIC_MASK);

   // pulse classes; runt works from the low level with slope-adjusted sense
   reg pulse_hit;
   always @* begin
      pulse_hit = 1'b0;
      case (PULSE_CLASS)
         `ATC_PULSE_WIDTH: pulse_hit = pulse_end & (pulse_len > PULSE_WIDTH);
         `ATC_PULSE_GLITCH: pulse_hit = pulse_end & (pulse_len < PULSE_WIDTH);
         `ATC_PULSE_RUNT: pulse_hit = ~act_low & low_prev & ~pulse_reached;
         default: pulse_hit = 1'b0;
      endcase
   end

   reg trig_hit;
   always @* begin
      trig_hit = 1'b0;
      case (TRIG_TYPE)
         `ATC_TYPE_EDGE: trig_hit = edge_hit;
         `ATC_TYPE_PULSE: trig_hit = pulse_hit;
         `ATC_TYPE_LOGIC: trig_hit = LOGIC_STATE ? (edge_hit & match) : (match & ~match_prev);
         default: trig_hit = 1'b0;
      endcase
   end
   wire real_trig = SAMPLE_VALID & trig_hit;

   // detector history, advanced only on samples
   always @(posedge REF_CLK) begin
      if (RST) begin
         src_prev <= 1'b0;
         low_prev <= 1'b0;
         match_prev <= 1'b0;
         pulse_reached <= 1'b0;
         pulse_len <= 16'h0000;
      end else if (SAMPLE_VALID) begin
         src_prev <= act;
         low_prev <= act_low;
         match_prev <= match;
         if (act & ~src_prev) begin
            pulse_len <= 16'h0001;
         end else if (act && pulse_len != 16'hFFFF) begin
            pulse_len <= pulse_len + 16'h0001;
         end
         if (act_low & ~low_prev) begin
            pulse_reached <= act;
         end else if (act) begin
            pulse_reached <= 1'b1;
         end
      end
   end

   wire auto_exp = AUTO_MODE && (auto_cnt >= (AUTO_CYC << HORIZ_SCALE));
   wire take = SAMPLE_VALID & (real_trig | force_pend | auto_exp);
   wire writing = SAMPLE_VALID & (state == S_PRE || state == S_ARM || state == S_POST);
   wire [AW-1:0] post_len = REC_LEN - PRE_LEN;

   // acquisition sequence
   always @(posedge REF_CLK) begin
      if (RST) begin
         state <= S_IDLE;
         waddr <= {AW{1'b0}};
         fill_cnt <= {AW{1'b0}};
         hold_cnt <= 32'h0000_0000;
         auto_cnt <= 32'h0000_0000;
         force_pend <= 1'b0;
         TRIG_ADDR <= {AW{1'b0}};
         ACQ_DONE <= 1'b0;
         AUTO_FIRED <= 1'b0;
      end else begin
         ACQ_DONE <= 1'b0;
         AUTO_FIRED <= 1'b0;
         // a new request wins over the clear of a consumed one
         if (FORCE_TRIG) begin
            force_pend <= 1'b1;
         end else if (state == S_ARM && take) begin
            force_pend <= 1'b0;
         end
         if (writing) begin
            waddr <= waddr + {{(AW-1){1'b0}}, 1'b1};
         end
         // auto timer restarts on each real trigger event
         if (real_trig || state != S_ARM) begin
            auto_cnt <= 32'h0000_0000;
         end else begin
            auto_cnt <= auto_cnt + 32'h0000_0001;
         end
         case (state)
            S_IDLE: begin
               fill_cnt <= {AW{1'b0}};
               if (RUN) begin
                  state <= S_PRE;
               end
            end
            // fill the pretrigger depth before a trigger may count
            S_PRE: begin
               if (SAMPLE_VALID) begin
                  fill_cnt <= fill_cnt + {{(AW-1){1'b0}}, 1'b1};
               end
               if (fill_cnt >= PRE_LEN) begin
                  state <= S_ARM;
               end
            end
            // samples keep circling; normal mode waits on a real or forced trigger only
            S_ARM: begin
               if (take) begin
                  TRIG_ADDR <= waddr;
                  AUTO_FIRED <= ~real_trig & ~force_pend & auto_exp;
                  fill_cnt <= {AW{1'b0}};
                  state <= S_POST;
               end
            end
            // further triggers are not looked at here
            S_POST: begin
               if (SAMPLE_VALID) begin
                  fill_cnt <= fill_cnt + {{(AW-1){1'b0}}, 1'b1};
               end
               if (SAMPLE_VALID && fill_cnt + {{(AW-1){1'b0}}, 1'b1} >= post_len) begin
                  ACQ_DONE <= 1'b1;
                  hold_cnt <= holdoff_cycles(HOLDOFF_PCT, HORIZ_SCALE);
                  state <= S_HOLD;
               end
            end
            // detector disabled; the record is frozen so the reader can fetch it
            S_HOLD: begin
               if (hold_cnt != 32'h0000_0000) begin
                  hold_cnt <= hold_cnt - 32'h0000_0001;
               end else begin
                  fill_cnt <= {AW{1'b0}};
                  state <= RUN ? S_PRE : S_IDLE;
               end
            end
            default: state <= S_IDLE;
         endcase
      end
   end

   assign ARMED = (state == S_ARM);
   assign STATE = state;

   atc_record_mem #(
      .DW(4*SW),
      .AW(AW)
   ) u_mem (
      .clk(REF_CLK),
      .we(writing),
      .waddr(waddr),
      .wdata(CH_DATA),
      .raddr(RD_ADDR),
      .rdata(RD_DATA)
   );
endmodule // atc_trigger

// file: tb/acquisition_trigger_control_tb.sv
// self-checking bench: trigger controller fed by the channel source model
// assumes shortened holdoff, auto and line counts set at the instance
`timescale 1ns/100ps
module acquisition_trigger_control_tb;
   reg clk = 1'b0, rst = 1'b1, run = 1'b0, aux = 1'b0, slow = 1'b0, slope = 1'b0, auto = 1'b0, frc = 1'b0;
   reg [2:0] src = 3'h0;
   reg [1:0] typ = 2'h0;
   reg [7:0] lv = 8'h80;
   reg [6:0] pct = 7'h00;
   reg [3:0] sc = 4'h0, msk = 4'h1;
   reg [1:0] pcls = 2'h0;
   reg lor = 1'b0, lst = 1'b0;
   reg [7:0] lvl_lo = 8'h08;
   reg [15:0] pwid = 16'h0004;
   reg [9:0] pre = 10'h004, rec = 10'h008, ra = 10'h000, t;
   reg [31:0] word = 32'h0000_0000, w0, w1;
   wire sv, done, afire, armed;
   wire [31:0] chd, rd;
   wire [9:0] ta;
   wire [2:0] st;
   int failures = 0, samples_checked = 0, cyc = 0, dn = 0, td = 0, af = 0, an = 0, al = 0, i, k;
   atc_chan_model src_m (.clk(clk), .slow(slow), .word(word), .valid(sv), .data(chd));
   atc_trigger #(.LINE_HALF(10), .HO_MIN(2), .HO_MAX(20), .AUTO_CYC(50)) dut (.REF_CLK(clk), .RST(rst),
      .RUN(run), .SAMPLE_VALID(sv), .CH_DATA(chd), .AUX_TRIG_PIN(aux), .TRIG_SOURCE(src), .TRIG_TYPE(typ),
      .TRIG_LEVEL(lv), .TRIG_LEVEL_LOW(lvl_lo), .SLOPE_FALLING(slope), .AUTO_MODE(auto), .FORCE_TRIG(frc),
      .HOLDOFF_PCT(pct), .HORIZ_SCALE(sc), .PRE_LEN(pre), .REC_LEN(rec), .PULSE_CLASS(pcls),
      .PULSE_WIDTH(pwid), .LOGIC_MASK(msk), .LOGIC_PATTERN(msk), .LOGIC_OR(lor), .LOGIC_STATE(lst),
      .RD_ADDR(ra), .RD_DATA(rd), .TRIG_ADDR(ta), .ACQ_DONE(done), .AUTO_FIRED(afire), .ARMED(armed), .STATE(st));
   initial forever #5 clk = ~clk;
   // event log just after each rising edge, once outputs settle
   always @(posedge clk) begin
      #1;
      cyc = cyc + 1;
      if (done === 1'b1) begin
         dn = dn + 1;
         td = cyc;
      end
      if (afire === 1'b1) begin
         af = af + 1;
         al = an;
      end
      an = (armed === 1'b1) ? an + 1 : 0;
   end
   task tally_and_finish;
      begin
         $display("checks %0d failures %0d", samples_checked, failures);
         if (failures == 0 && samples_checked > 0)
            $display("Test passed");
         else
            $display("Test failed");
         $finish;
      end
   endtask
   task chk_word(input [31:0] g, input [31:0] e);
      begin
         samples_checked++;
         if (g !== e) begin
            failures++;
            $display("unexpected %0t word %h not %h", $time, g, e);
         end
      end
   endtask
   task chk_cnt(input int g, input int e);
      begin
         samples_checked++;
         if (g != e) begin
            failures++;
            $display("unexpected %0t count %0d not %0d", $time, g, e);
         end
      end
   endtask
   // bounded wait: kind 0 state, 1 acquisitions, 2 auto fires
   task wfor(input int kind, input int v);
      int n;
      begin
         n = 0;
         while ((kind == 0 ? st !== v[2:0] : kind == 1 ? dn < v : af < v) && n < 600) begin
            @(negedge clk);
            n++;
         end
         if (n >= 600) begin
            chk_cnt(n, 0);
            tally_and_finish;
         end
      end
   endtask
   // one sample, held until the source marks it valid
   task put(input [31:0] v);
      begin
         @(negedge clk);
         word = v;
         @(posedge clk);
         if (sv !== 1'b1)
            @(posedge clk);
         #1;
      end
   endtask
   // one triggered record on channel c with crossings thrown at it while filling
   task run_rec(input int c);
      begin
         @(negedge clk);
         lv = 8'h10 + $urandom % 200;
         pct = $urandom % 101;
         sc = $urandom % 3;
         slow = $urandom % 2;
         w0 = $urandom;
         w1 = $urandom;
         w0[8*c +: 8] = slope ? lv + $urandom % 8 : lv - 8'h01 - $urandom % 8;
         w1[8*c +: 8] = slope ? lv - 8'h01 - $urandom % 8 : lv + $urandom % 8;
         // the old word may already be armed under the new level, so replace it at once
         word = w0;
         put(w0);
         for (k = 0; armed !== 1'b1 && k < 600; k++)
            put(w0);
         chk_cnt(k >= 600, 0);
         put(w1);
         t = ta;
         chk_word({29'h0000_0000, st}, 32'h0000_0003);
         k = dn;
         for (i = 1; i < rec - pre; i++)
            put(i % 2 ? w0 : w1);
         chk_cnt(dn, k);
         put(w0);
         repeat (2) @(negedge clk);
         chk_cnt(dn, k + 1);
         chk_word({22'h00_0000, ta}, {22'h00_0000, t});
         wfor(0, 1);
         chk_cnt(cyc - td, (2 << sc) + (18 << sc) * pct / 100 + 1);
         ra = t;
         @(negedge clk);
         ra = t - 10'h001;
         chk_word(rd, w1);
         @(negedge clk);
         chk_word(rd, w0);
      end
   endtask
   // one pulse of len samples at level hv on channel 0, from and back to zero
   task pulse_rec(input [1:0] cls, input [7:0] hv, input int len, input bit hit);
      begin
         @(negedge clk);
         pcls = cls;
         wfor(0, 2);
         put(32'h0000_0000);
         repeat (len) put({24'h00_0000, hv});
         put(32'h0000_0000);
         chk_word({29'h0000_0000, st}, hit ? 32'h0000_0003 : 32'h0000_0002);
      end
   endtask
   initial begin
      i = $urandom(32'h758f989f);
      pre = 10'h002 + $urandom % 4;
      rec = pre + 10'h002 + $urandom % 5;
      repeat (6) @(negedge clk);
      rst = 1'b0;
      run = 1'b1;
      for (int r = 0; r < 12; r++) begin
         typ = (r < 8) ? 2'h0 : 2'h2;
         slope = (r / 4 == 1);
         msk = 4'h1 << (r % 4);
         src = {1'b0, r[1:0]};
         lst = r[0];
         lor = r[1];
         run_rec(r % 4);
      end
      // pulse classes on channel 0 from a quiet baseline; each miss must leave it armed
      typ = 2'h1;
      src = 3'h0;
      slope = 1'b0;
      slow = 1'b0;
      word = 32'h0000_0000;
      pulse_rec(2'h0, 8'hff, 4, 1'b0);
      pulse_rec(2'h0, 8'hff, 5, 1'b1);
      pulse_rec(2'h2, 8'hff, 4, 1'b0);
      pulse_rec(2'h2, 8'hff, 3, 1'b1);
      pulse_rec(2'h1, 8'hff, 1, 1'b0);
      pulse_rec(2'h1, 8'h08, 1, 1'b1);
      // quiet input in normal mode: only a forced trigger records
      wfor(0, 2);
      typ = 2'h0;
      k = dn;
      repeat (150) @(negedge clk);
      chk_cnt(dn, k);
      frc = 1'b1;
      @(negedge clk);
      frc = 1'b0;
      repeat (150) @(negedge clk);
      chk_cnt(dn, k + 1);
      auto = 1'b1;
      for (int r = 0; r < 2; r++) begin
         sc = r;
         wfor(2, af + 1);
         wfor(2, af + 1);
         // timer starts from zero at arm entry, so the fire edge lands one cycle after the count
         chk_cnt(al, (50 << r) + 1);
      end
      auto = 1'b0;
      src = 3'h4;
      // let the auto-fired record finish so only a line edge can complete the next one
      wfor(0, 2);
      wfor(1, dn + 1);
      src = 3'h5;
      wfor(0, 2);
      aux = 1'b1;
      wfor(1, dn + 1);
      aux = 1'b0;
      tally_and_finish;
   end
endmodule // acquisition_trigger_control_tb

// file: tb/atc_chan_model.sv
// channel source model: four sampled channels carried on one word
// assumes the bench changes word between clock edges
`timescale 1ns/100ps
module atc_chan_model (
   input wire clk,
   input wire slow,
   input wire [31:0] word,
   output reg valid = 1'b0,
   output wire [31:0] data
);
   reg ph = 1'b0;
   // slow pacing drops every other sample, like a decimating digitizer
   always @(negedge clk) begin
      ph <= ~ph;
      valid <= ~slow | ph;
   end
   assign data = word;
endmodule // atc_chan_model

// file: tb/atc_properties.sv
// checker for the trigger controller ports
// assumes one clock and the synchronous reset RST
`timescale 1ns/100ps
module atc_properties #(parameter AW = 10) (
   input wire REF_CLK,
   input wire RST,
   input wire SAMPLE_VALID,
   input wire AUTO_MODE,
   input wire [AW-1:0] TRIG_ADDR,
   input wire ACQ_DONE,
   input wire AUTO_FIRED,
   input wire ARMED,
   input wire [2:0] STATE
);
   default clocking @(posedge REF_CLK); endclocking
   default disable iff (RST);
   // state order and trigger acceptance
   a_take_armed: assert property ($rose(STATE == 3'h3) |-> $past(ARMED && SAMPLE_VALID)) else $error("bad take");
   a_arm_pre: assert property ($rose(STATE == 3'h2) |-> $past(STATE) == 3'h1) else $error("bad arm");
   a_done_post: assert property (ACQ_DONE |-> $past(STATE) == 3'h3 ##1 !ACQ_DONE) else $error("bad done");
   a_addr_held: assert property (!$rose(STATE == 3'h3) |-> $stable(TRIG_ADDR)) else $error("addr moved");
   // holdoff keeps the detector shut for at least two cycles
   a_hold_min: assert property ($rose(STATE == 3'h4) |-> (STATE == 3'h4)[*2]) else $error("short hold");
   a_hold_shut: assert property ($past(STATE) == 3'h4 |-> STATE != 3'h3) else $error("hold take");
   // forced triggers by timeout only in auto mode
   a_auto_why: assert property (AUTO_FIRED |-> $past(ARMED && AUTO_MODE) && STATE == 3'h3) else $error("bad auto");
   a_norm_quiet: assert property (!$past(AUTO_MODE) |-> !AUTO_FIRED) else $error("auto in normal");
   cover property (ACQ_DONE);
   cover property (AUTO_FIRED);
   cover property ($rose(STATE == 3'h4));
endmodule // atc_properties
bind atc_trigger atc_properties #(.AW(AW)) u_props (.REF_CLK(REF_CLK), .RST(RST), .SAMPLE_VALID(SAMPLE_VALID),
   .AUTO_MODE(AUTO_MODE), .TRIG_ADDR(TRIG_ADDR), .ACQ_DONE(ACQ_DONE), .AUTO_FIRED(AUTO_FIRED), .ARMED(ARMED),
   .STATE(STATE));
